// ### common/ppf_pkg.sv
`default_nettype none
package ppf_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [3:0] PPF_OFS_P3    = 4'h0; // Timer shared port
    localparam logic [3:0] PPF_OFS_P6    = 4'h1; // Analog shared port
    localparam logic [3:0] PPF_OFS_P7    = 4'h2; // Key input port
    localparam logic [3:0] PPF_OFS_P8    = 4'h3; // Single bit port
    localparam logic [3:0] PPF_OFS_DIRA3 = 4'h4; // Direction A, low
    localparam logic [3:0] PPF_OFS_DIRA6 = 4'h5; // Direction A, high
    localparam logic [3:0] PPF_OFS_DIRC  = 4'h6; // Direction C
    localparam logic [3:0] PPF_OFS_PUA   = 4'h7; // Pull-up select A
    localparam logic [3:0] PPF_OFS_PUB   = 4'h8; // Pull-up select B
    localparam logic [3:0] PPF_OFS_EIM   = 4'h9; // Ext irq edge mode
    localparam logic [3:0] PPF_OFS_KIM   = 4'ha; // Key irq source mode

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PPF_PU_P3_BIT   = 0; // Pull-up A, timer port
    localparam int PPF_PU_P6_BIT   = 1; // Pull-up A, analog port
    localparam int PPF_EIM_FLT_BIT = 2; // Noise filter connect
    localparam int PPF_EIM_RTE_BIT = 3; // Filter slow rate

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [3:0] PPF_RST_LATCH = 4'h0;
    localparam logic [3:0] PPF_RST_DIR   = 4'h0;
    localparam logic [3:0] PPF_RST_MODE  = 4'h0;

    // ************************************************************
    // Filter sampling dividers (terminal counts)
    // ************************************************************
    localparam logic [5:0] PPF_FLT_FAST = 6'h03;
    localparam logic [5:0] PPF_FLT_SLOW = 6'h3f;

    // Edge choice of the external interrupt input
    typedef enum logic [1:0] {
        PPF_EDGE_RISE = 2'b00,
        PPF_EDGE_FALL = 2'b01,
        PPF_EDGE_BOTH = 2'b10,
        PPF_EDGE_OFF  = 2'b11
    } ppf_edge_t;

    // One register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [3:0] wdata;
        logic       wr;
        logic       rd;
        logic       bit_op;
        logic [1:0] bit_sel;
    } ppf_bus_req_t;

endpackage
`default_nettype wire

// ### src/ppf_port_pins.sv
// The register addresses and the strobed register port were left to the implementer.
`default_nettype none
// How it works
// RULE1 - Per-pin direction, groups A and C
// RULE2 - Pull-ups per 4-bit port, single bit
// RULE3 - Bit or nibble access, no 8-bit
// RULE4 - Reset makes every port pin input
// RULE5 - Key pins are always inputs
// RULE6 - Timer wave drives pin: latch 0, output
// RULE7 - Timer start clears output flip-flop
// RULE8 - Two bits pick interrupt edge
// RULE9 - Reset selects rising edge
// RULE10 - Unfiltered input accepts pulse directly
// RULE11 - Optional noise filter, two sample rates
// RULE12 - Ext edge releases standby unless filtered
// RULE13 - Key falling edges form one source
// RULE14 - After reset keys are plain inputs
// RULE15 - Enable high, stop: key edge resets
// RULE16 - Enable low: never reset from keys
// RULE17 - Reset asynchronous, above everything
// RULE18 - Reset also releases stop and halt
// RULE19 - Software keeps analog pull-up off
// RULE20 - Latch kept in input, driven later
module ppf_port_pins
    import ppf_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    // Register port
    input  wire ppf_bus_req_t bus_i,
    output logic [3:0]        rdata_o,
    // Timer shared port pins
    input  wire logic [3:0]   p3_in_i,
    output logic [3:0]        p3_out_o,
    output logic [3:0]        p3_oe_o,
    output logic              p3_pu_o,
    // Analog shared port pins
    input  wire logic [3:0]   p6_in_i,
    output logic [3:0]        p6_out_o,
    output logic [3:0]        p6_oe_o,
    output logic              p6_pu_o,
    // Single bit port pin
    input  wire logic         p8_in_i,
    output logic              p8_out_o,
    output logic              p8_oe_o,
    output logic              p8_pu_o,
    // Key input port pins and key reset enable pin
    input  wire logic [3:0]   p7_in_i,
    input  wire logic         krr_en_i,
    // Timer side
    input  wire logic [2:0]   timer_toggle_i,
    input  wire logic [2:0]   timer_start_i,
    // CPU standby state
    input  wire logic         stop_mode_i,
    input  wire logic         halt_mode_i,
    // Events
    output logic              ext_irq_o,
    output logic              key_irq_o,
    output logic              standby_release_o,
    output logic              key_reset_o
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [3:0] lat3;      // Output latch, timer port
    logic [3:0] lat6;      // Output latch, analog port
    logic       lat8;      // Output latch, single bit
    logic [3:0] dir3;      // Direction A low
    logic [3:0] dir6;      // Direction A high
    logic       dir8;      // Direction C
    logic [1:0] pua;       // Pull-up select A
    logic       pub;       // Pull-up select B
    logic [3:0] eim;       // Ext irq edge mode
    logic       kim;       // Key irq source enable
    logic [2:0] tff;       // Timer output flip-flops

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [13:0] sync1;    // First stage
    logic [13:0] sync2;    // Second stage
    logic [3:0]  pin3;
    logic [3:0]  pin6;
    logic        pin8;
    logic [3:0]  pin7;
    logic        krr_q;

    // Two flip-flops on every pin input
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i) // RULE17
        begin
            sync1 <= 14'h0000;
            sync2 <= 14'h0000;
        end
        else
        begin
            sync1 <= {p3_in_i, p6_in_i, p8_in_i, p7_in_i, krr_en_i};
            sync2 <= sync1;
        end
    end

    assign {pin3, pin6, pin8, pin7, krr_q} = sync2;

    // ************************************************************
    // Write decode
    // ************************************************************
    wire wr_p3  = bus_i.wr && (bus_i.addr == PPF_OFS_P3);
    wire wr_p6  = bus_i.wr && (bus_i.addr == PPF_OFS_P6);
    wire wr_p8  = bus_i.wr && (bus_i.addr == PPF_OFS_P8);
    wire wr_d3  = bus_i.wr && (bus_i.addr == PPF_OFS_DIRA3);
    wire wr_d6  = bus_i.wr && (bus_i.addr == PPF_OFS_DIRA6);
    wire wr_d8  = bus_i.wr && (bus_i.addr == PPF_OFS_DIRC);
    wire wr_pua = bus_i.wr && (bus_i.addr == PPF_OFS_PUA);
    wire wr_pub = bus_i.wr && (bus_i.addr == PPF_OFS_PUB);
    wire wr_eim = bus_i.wr && (bus_i.addr == PPF_OFS_EIM);
    wire wr_kim = bus_i.wr && (bus_i.addr == PPF_OFS_KIM);

    // Bit mask of one access: single bit or whole nibble
    wire [3:0] acc_mask = bus_i.bit_op ? (4'h1 << bus_i.bit_sel)
                                       : 4'hf;
    wire [3:0] acc_data = bus_i.bit_op ? {4{bus_i.wdata[0]}}
                                       : bus_i.wdata;

    // Merge an access into an old nibble
    function automatic logic [3:0] upd(input logic [3:0] old);
        upd = (old & ~acc_mask) | (acc_data & acc_mask); // RULE3
    endfunction

    // Latches, independent of direction
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            lat3 <= PPF_RST_LATCH;
            lat6 <= PPF_RST_LATCH;
            lat8 <= 1'b0;
        end
        else
        begin
            if (wr_p3)
                lat3 <= upd(lat3); // RULE20
            if (wr_p6)
                lat6 <= upd(lat6);
            if (wr_p8)
                lat8 <= 1'(upd({3'h0, lat8}));
        end
    end

    // Direction, pull-up and mode registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            dir3 <= PPF_RST_DIR; // RULE4
            dir6 <= PPF_RST_DIR;
            dir8 <= 1'b0;
            pua  <= 2'b00;
            pub  <= 1'b0;
            eim  <= PPF_RST_MODE; // RULE9
            kim  <= 1'b0; // RULE14
        end
        else
        begin
            if (wr_d3)
                dir3 <= upd(dir3); // RULE1
            if (wr_d6)
                dir6 <= upd(dir6);
            if (wr_d8)
                dir8 <= 1'(upd({3'h0, dir8}));
            if (wr_pua)
                pua <= 2'(upd({2'b00, pua})); // RULE2
            if (wr_pub)
                pub <= 1'(upd({3'h0, pub}));
            if (wr_eim)
                eim <= upd(eim); // RULE8
            if (wr_kim)
                kim <= 1'(upd({3'h0, kim})); // RULE13
        end
    end

    // ************************************************************
    // Read port, data one cycle after the strobe
    // ************************************************************
    logic [3:0] rd_val;   // Addressed nibble
    wire  [3:0] rd_bit = {3'h0, rd_val[bus_i.bit_sel]};

    // Register select
    always_comb
    begin
        if (bus_i.addr == PPF_OFS_P3)
            rd_val = pin3;
        else if (bus_i.addr == PPF_OFS_P6)
            rd_val = pin6;
        else if (bus_i.addr == PPF_OFS_P7)
            rd_val = pin7; // RULE5
        else if (bus_i.addr == PPF_OFS_P8)
            rd_val = {3'h0, pin8};
        else if (bus_i.addr == PPF_OFS_DIRA3)
            rd_val = dir3;
        else if (bus_i.addr == PPF_OFS_DIRA6)
            rd_val = dir6;
        else if (bus_i.addr == PPF_OFS_DIRC)
            rd_val = {3'h0, dir8};
        else if (bus_i.addr == PPF_OFS_PUA)
            rd_val = {2'b00, pua};
        else if (bus_i.addr == PPF_OFS_PUB)
            rd_val = {3'h0, pub};
        else if (bus_i.addr == PPF_OFS_EIM)
            rd_val = eim;
        else if (bus_i.addr == PPF_OFS_KIM)
            rd_val = {3'h0, kim};
        else
            rd_val = 4'h0; // Unmapped reads zero
    end

    // Read data register
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rdata_o <= 4'h0;
        else if (bus_i.rd)
            rdata_o <= bus_i.bit_op ? rd_bit : rd_val; // RULE3
        else
            rdata_o <= 4'h0;
    end

    // ************************************************************
    // Timer output flip-flops and pin drive
    // ************************************************************
    logic [3:0] drv3;     // Next level of the timer port

    for (genvar k = 0; k < 4; k++)
    begin : g_tmr
        if (k < 3)
        begin : g_ff
            // Start clears, toggle flips
            always_ff @(posedge clk_sys_i or posedge sys_rst_i)
            begin
                if (sys_rst_i)
                    tff[k] <= 1'b0;
                else if (timer_start_i[k])
                    tff[k] <= 1'b0; // RULE7
                else if (timer_toggle_i[k])
                    tff[k] <= ~tff[k];
            end
            // Wave only when the latch holds zero
            assign drv3[k] = lat3[k] | tff[k]; // RULE6
        end
        else
        begin : g_plain
            assign drv3[k] = lat3[k];
        end
    end

    // Registered pin outputs
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            p3_out_o <= 4'h0;
            p3_oe_o  <= 4'h0; // RULE4
            p6_out_o <= 4'h0;
            p6_oe_o  <= 4'h0;
            p8_out_o <= 1'b0;
            p8_oe_o  <= 1'b0;
            p3_pu_o  <= 1'b0;
            p6_pu_o  <= 1'b0;
            p8_pu_o  <= 1'b0;
        end
        else
        begin
            p3_out_o <= drv3; // RULE20
            p3_oe_o  <= dir3; // RULE1
            p6_out_o <= lat6;
            p6_oe_o  <= dir6;
            p8_out_o <= lat8;
            p8_oe_o  <= dir8;
            p3_pu_o  <= pua[PPF_PU_P3_BIT]; // RULE2
            p6_pu_o  <= pua[PPF_PU_P6_BIT]; // RULE19
            p8_pu_o  <= pub;
        end
    end

    // ************************************************************
    // External interrupt input with optional filter
    // ************************************************************
    wire        flt_on  = eim[PPF_EIM_FLT_BIT];
    wire  [5:0] flt_tc  = eim[PPF_EIM_RTE_BIT] ? PPF_FLT_SLOW
                                               : PPF_FLT_FAST;
    wire        ext_raw = pin6[1];
    logic [5:0] flt_cnt;  // Sample divider
    logic       flt_smp;  // Last sample
    logic       flt_lvl;  // Filtered level
    logic       ext_prv;  // Previous chosen level
    wire        smp_en  = (flt_cnt >= flt_tc);
    wire        ext_lvl = flt_on ? flt_lvl : ext_raw;

    // Filter: two equal samples in a row pass
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            flt_cnt <= 6'h00;
            flt_smp <= 1'b0;
            flt_lvl <= 1'b0;
        end
        else
        begin
            flt_cnt <= smp_en ? 6'h00 : flt_cnt + 6'h01;
            if (smp_en)
            begin
                flt_smp <= ext_raw;
                if (flt_smp == ext_raw)
                    flt_lvl <= ext_raw; // RULE11
            end
        end
    end

    wire rise = ext_lvl & ~ext_prv;
    wire fall = ~ext_lvl & ext_prv;

    // Edge choice
    logic ext_hit;
    always_comb
    begin
        case (ppf_edge_t'(eim[1:0]))
            PPF_EDGE_RISE: ext_hit = rise; // RULE8
            PPF_EDGE_FALL: ext_hit = fall;
            PPF_EDGE_BOTH: ext_hit = rise | fall;
            default:       ext_hit = 1'b0;
        endcase
    end

    // ************************************************************
    // Key inputs
    // ************************************************************
    logic [3:0] key_prv;  // Previous key levels
    wire key_fall = |(key_prv & ~pin7); // RULE13
    wire key_rst  = key_fall & krr_q & stop_mode_i; // RULE15
    wire key_rel  = key_fall & kim & ~krr_q; // RULE16
    wire ext_rel  = ext_hit & ~flt_on; // RULE12
    wire standby  = stop_mode_i | halt_mode_i;

    // Edge history and event outputs
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ext_prv           <= 1'b0;
            key_prv           <= 4'h0;
            ext_irq_o         <= 1'b0;
            key_irq_o         <= 1'b0;
            standby_release_o <= 1'b1; // RULE18
            key_reset_o       <= 1'b0;
        end
        else
        begin
            ext_prv           <= ext_lvl;
            key_prv           <= pin7;
            ext_irq_o         <= ext_hit; // RULE10
            key_irq_o         <= key_fall & kim;
            standby_release_o <= key_rst
                                 | (standby & (ext_rel | key_rel));
            key_reset_o       <= key_rst; // RULE16
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_key_stop;
        key_fall && krr_q && stop_mode_i;
    endsequence

    sequence s_ext_filtered;
        ext_hit && flt_on && !key_rel && !key_rst;
    endsequence

    property p_oe_reset;
        @(posedge clk_sys_i) $past(sys_rst_i) |->
            (p3_oe_o == 4'h0) && (p6_oe_o == 4'h0) && !p8_oe_o;
    endproperty
    a_oe_reset: assert property (p_oe_reset) // RULE4
        else $error("port pin driven after reset");

    property p_eim_reset;
        @(posedge clk_sys_i) $past(sys_rst_i) |-> eim == 4'h0;
    endproperty
    a_eim_reset: assert property (p_eim_reset) // RULE9
        else $error("edge mode not rising after reset");

    property p_wave;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        dir3[0] && !lat3[0] && !wr_p3 && !wr_d3 ##1 !timer_toggle_i[0]
            |-> p3_oe_o[0] && (p3_out_o[0] == $past(tff[0]));
    endproperty
    a_wave: assert property (p_wave) // RULE6
        else $error("timer wave not on pin");

    property p_start;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        timer_start_i[0] |=> !tff[0] ##1 (p3_out_o[0] == lat3[0]
            || $past(timer_toggle_i[0]) || $past(wr_p3));
    endproperty
    a_start: assert property (p_start) // RULE7
        else $error("timer start did not clear flip-flop");

    property p_key_reset;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        s_key_stop |=> key_reset_o && standby_release_o;
    endproperty
    a_key_reset: assert property (p_key_reset) // RULE15
        else $error("key edge in stop gave no reset");

    property p_no_key_reset;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !krr_q |=> !key_reset_o;
    endproperty
    a_no_key_reset: assert property (p_no_key_reset) // RULE16
        else $error("key reset while enable low");

    property p_filter_no_release;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        s_ext_filtered |=> !standby_release_o;
    endproperty
    a_filter_no_release: assert property (p_filter_no_release) // RULE12
        else $error("filtered edge released standby");

    property p_bit_write;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_p3 && bus_i.bit_op |=>
            ((lat3 ^ $past(lat3)) & ~$past(acc_mask)) == 4'h0;
    endproperty
    a_bit_write: assert property (p_bit_write) // RULE3
        else $error("bit write touched other bits");

    property p_latch_kept;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_p3 && !dir3[3] ##1 !wr_p3 [*2]
            |-> p3_out_o[3] == $past(lat3[3], 1);
    endproperty
    a_latch_kept: assert property (p_latch_kept) // RULE20
        else $error("latch lost while in input mode");

endmodule // ppf_port_pins
`default_nettype wire

// ### verif/ppf_pin_model.sv
`default_nettype none
// ****************************************
// Board side of a group of two-way pins
// ****************************************
module ppf_pin_model #(
    parameter int W = 4              // Pins in the group
) (
    // Clock for the undriven pattern
    input  wire logic         clk_i,
    // Device side
    input  wire logic [W-1:0] out_i, // Device drive level
    input  wire logic [W-1:0] oe_i,  // Device drive enable
    input  wire logic         pu_i,  // Device pull-up
    // Board side
    input  wire logic [W-1:0] ext_i, // Board drive level
    input  wire logic [W-1:0] ext_en_i, // Board drive enable
    output logic      [W-1:0] lvl_o  // Resolved pin level
);
    timeunit 1ns;
    timeprecision 1ns;

    logic float_q = 1'h0; // Undriven pin wanders every cycle

    // Pattern so that a floating pin never looks stable
    always @(posedge clk_i)
        float_q <= ~float_q;

    // Device drive first, then board, then pull-up
    always_comb
        for (int i = 0; i < W; i++)
            lvl_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_i[i]
                     : pu_i ? 1'h1 : float_q;
endmodule // ppf_pin_model
`default_nettype wire

// ### verif/ppf_port_pins_tb.sv
`default_nettype none
// ****************************************
// Self-checking bench of the port pins
// ****************************************
module ppf_port_pins_tb import ppf_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    logic         clk_sys_i = 1'h0;      // System clock
    logic         sys_rst_i = 1'h1;      // Reset, active high
    ppf_bus_req_t bus       = '0;        // Register request
    logic [3:0]   rdata, p3_in, p3_out, p3_oe, p6_in, p6_out, p6_oe;
    logic [3:0]   p7, e3, e6, en3, en6;  // Key pins, board levels
    logic         p3_pu, p6_pu, p8_in, p8_out, p8_oe, p8_pu, krr, e8, en8;
    logic [2:0]   tgl, tst;              // Timer toggle and start
    logic         stop, halt, ext_irq, key_irq, rel, kres;
    logic         rd_q;                  // Read taken last edge
    logic [3:0]   exp_q[$];              // Expected read data
    logic [3:0]   exp_irq [4] = '{4'h1, 4'h1, 4'h2, 4'h0};
    logic [31:0]  lfsr = 32'hfb11;       // Random source
    int           failures = 0, n_compared = 0;
    int           n_ext = 0, n_key = 0, n_rel = 0, n_kr = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    ppf_port_pins u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .bus_i(bus), .rdata_o(rdata), .p3_in_i(p3_in),
        .p3_out_o(p3_out), .p3_oe_o(p3_oe), .p3_pu_o(p3_pu),
        .p6_in_i(p6_in), .p6_out_o(p6_out), .p6_oe_o(p6_oe),
        .p6_pu_o(p6_pu), .p8_in_i(p8_in), .p8_out_o(p8_out),
        .p8_oe_o(p8_oe), .p8_pu_o(p8_pu), .p7_in_i(p7), .krr_en_i(krr),
        .timer_toggle_i(tgl), .timer_start_i(tst), .stop_mode_i(stop),
        .halt_mode_i(halt), .ext_irq_o(ext_irq), .key_irq_o(key_irq),
        .standby_release_o(rel), .key_reset_o(kres));
    ppf_pin_model #(.W(4)) u_p3 (.clk_i(clk_sys_i), .out_i(p3_out),
        .oe_i(p3_oe), .pu_i(p3_pu), .ext_i(e3), .ext_en_i(en3),
        .lvl_o(p3_in));
    ppf_pin_model #(.W(4)) u_p6 (.clk_i(clk_sys_i), .out_i(p6_out),
        .oe_i(p6_oe), .pu_i(p6_pu), .ext_i(e6), .ext_en_i(en6),
        .lvl_o(p6_in));
    ppf_pin_model #(.W(1)) u_p8 (.clk_i(clk_sys_i), .out_i(p8_out),
        .oe_i(p8_oe), .pu_i(p8_pu), .ext_i(e8), .ext_en_i(en8),
        .lvl_o(p8_in));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [3:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus cycle, then idle for a cycle
    task automatic bus_op(input logic [3:0] a, d, input logic w, b);
        @(posedge clk_sys_i);
        bus <= '{addr: a, wdata: d, wr: w, rd: ~w, bit_op: b,
                 bit_sel: 2'h2};
        @(posedge clk_sys_i);
        bus <= '0;
    endtask
    task automatic reg_wr(input logic [3:0] a, d);
        bus_op(a, d, 1'h1, 1'h0);
    endtask
    task automatic reg_rd(input logic [3:0] a, e);
        exp_q.push_back(e);
        bus_op(a, 4'h0, 1'h0, 1'h0);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // One high pulse on the external interrupt pin
    task automatic pulse(input int w);
        e6[1] <= 1'h1;
        cyc(w);
        e6[1] <= 1'h0;
    endtask
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic give_verdict;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watch outputs: read data and event pulses
    always @(posedge clk_sys_i)
        rd_q <= bus.rd;
    always @(negedge clk_sys_i)
    begin
        n_ext += int'(ext_irq === 1'h1);
        n_key += int'(key_irq === 1'h1);
        n_rel += int'(rel === 1'h1);
        n_kr  += int'(kres === 1'h1);
        if (rd_q === 1'h1)
            chk("rdata", exp_q.pop_front(), rdata);
    end

    // Hang guard
    initial
    begin
        cyc(90000);
        failures++;
        give_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        int a, b;
        e3 = 4'h3;
        e6 = 4'h0;
        {en3, en6} = 8'hff;
        p7 = 4'hf;
        {krr, tgl, tst, stop, halt, e8, en8} = '0;
        cyc(4);
        chk("release", 4'h1, 4'(rel));
        chk("p3_oe", 4'h0, p3_oe);
        chk("p6_oe", 4'h0, p6_oe);
        chk("p8_oe", 4'h0, 4'(p8_oe));
        sys_rst_i <= 1'h0;
        reg_rd(PPF_OFS_EIM, 4'h0);
        reg_rd(PPF_OFS_KIM, 4'h0);
        reg_rd(PPF_OFS_P7, 4'hf);
        reg_wr(PPF_OFS_P7, 4'h0);
        reg_rd(PPF_OFS_P7, 4'hf);
        reg_rd(4'hf, 4'h0);
        $display("test reset done");
        // Latch written as input, driven once output
        reg_wr(PPF_OFS_P3, 4'ha);
        chk("p3_oe", 4'h0, p3_oe);
        reg_wr(PPF_OFS_DIRA3, 4'h5);
        cyc(3);
        chk("p3_oe", 4'h5, p3_oe);
        chk("p3_out", 4'ha, p3_out);
        reg_rd(PPF_OFS_P3, 4'h2);
        bus_op(PPF_OFS_P3, 4'h1, 1'h1, 1'h1);
        cyc(3);
        chk("p3_out", 4'he, p3_out);
        exp_q.push_back(4'h1);
        bus_op(PPF_OFS_P3, 4'h0, 1'h0, 1'h1);
        $display("test port access done");
        // Random latch values out, random board values in
        for (int i = 0; i < 4; i++)
        begin
            lfsr = nx(lfsr);
            reg_wr(PPF_OFS_DIRA3, 4'hf);
            reg_wr(PPF_OFS_P3, lfsr[3:0]);
            cyc(3);
            reg_rd(PPF_OFS_P3, lfsr[3:0]);
            reg_wr(PPF_OFS_DIRA3, 4'h0);
            e3 <= lfsr[7:4];
            cyc(3);
            reg_rd(PPF_OFS_P3, lfsr[7:4]);
        end
        $display("test random done");
        // Timer wave outputs
        reg_wr(PPF_OFS_DIRA3, 4'hf);
        reg_wr(PPF_OFS_P3, 4'h0);
        tgl <= 3'h5;
        cyc(1);
        tgl <= 3'h0;
        cyc(2);
        chk("p3_out", 4'h5, p3_out);
        {tgl, tst} <= {3'h2, 3'h5};
        cyc(1);
        {tgl, tst} <= 6'h00;
        cyc(2);
        chk("p3_out", 4'h2, p3_out);
        $display("test timer done");
        // Pull-ups and the single bit port
        reg_wr(PPF_OFS_PUA, 4'h1);
        reg_wr(PPF_OFS_PUB, 4'h1);
        reg_wr(PPF_OFS_DIRC, 4'h1);
        reg_wr(PPF_OFS_P8, 4'h1);
        reg_wr(PPF_OFS_DIRA6, 4'h8);
        reg_wr(PPF_OFS_P6, 4'h8);
        reg_rd(PPF_OFS_DIRC, 4'h1);
        chk("p3_pu", 4'h1, 4'(p3_pu));
        chk("p6_pu", 4'h0, 4'(p6_pu));
        chk("p8_pu", 4'h1, 4'(p8_pu));
        chk("p8_out", 4'h1, 4'(p8_out & p8_oe));
        chk("p6_out", 4'h8, p6_out & p6_oe);
        $display("test pull-up done");
        // Every edge choice, unfiltered, in halt
        halt <= 1'h1;
        for (int m = 0; m < 4; m++)
        begin
            reg_wr(PPF_OFS_EIM, 4'(m));
            cyc(8);
            {a, b} = {n_ext, n_rel};
            pulse(1);
            cyc(10);
            chk("ext_irq", exp_irq[m], 4'(n_ext - a));
            chk("release", exp_irq[m], 4'(n_rel - b));
        end
        // Filter: short pulses rejected, no standby release
        reg_wr(PPF_OFS_EIM, 4'h4);
        cyc(8);
        {a, b} = {n_ext, n_rel};
        pulse(1);
        cyc(20);
        pulse(40);
        cyc(40);
        chk("ext_irq", 4'h1, 4'(n_ext - a));
        chk("release", 4'h0, 4'(n_rel - b));
        reg_wr(PPF_OFS_EIM, 4'hc);
        cyc(140);
        a = n_ext;
        pulse(20);
        cyc(140);
        pulse(200);
        cyc(200);
        chk("ext_irq", 4'h1, 4'(n_ext - a));
        halt <= 1'h0;
        $display("test external input done");
        // Key falling edges, each pin
        reg_wr(PPF_OFS_KIM, 4'h1);
        a = n_key;
        for (int i = 0; i < 4; i++)
        begin
            p7 <= ~(4'h1 << i);
            cyc(8);
            p7 <= 4'hf;
            cyc(8);
        end
        chk("key_irq", 4'h4, 4'(n_key - a));
        // Enable low in stop: release only
        stop <= 1'h1;
        {a, b} = {n_kr, n_rel};
        p7 <= 4'h7;
        cyc(8);
        chk("key_reset", 4'h0, 4'(n_kr - a));
        chk("release", 4'h1, 4'(n_rel - b));
        p7 <= 4'hf;
        krr <= 1'h1;
        reg_wr(PPF_OFS_KIM, 4'h0);
        cyc(6);
        {a, b} = {n_kr, n_rel};
        p7 <= 4'hb;
        for (int k = 0; k < 10 && n_kr == a; k++)
            cyc(1);
        cyc(3);
        chk("key_reset", 4'h1, 4'(n_kr - a));
        chk("release", 4'h1, 4'(n_rel - b));
        {stop, krr, p7} <= {2'h0, 4'hf};
        $display("test key input done");
        // Reset in mid-run acts before the next edge
        reg_wr(PPF_OFS_DIRA3, 4'hf);
        reg_wr(PPF_OFS_EIM, 4'h2);
        cyc(1);
        sys_rst_i <= 1'h1;
        @(negedge clk_sys_i);
        chk("p3_oe", 4'h0, p3_oe);
        chk("release", 4'h1, 4'(rel));
        cyc(2);
        sys_rst_i <= 1'h0;
        reg_rd(PPF_OFS_DIRA3, 4'h0);
        reg_rd(PPF_OFS_EIM, 4'h0);
        cyc(4);
        $display("test reset in mid-run done");
        give_verdict();
    end
endmodule // ppf_port_pins_tb
`default_nettype wire
